// *** adc_pkg.sv ***
package adc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIM_LEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_NONE = 8'hff;

  // control fields
  localparam int CTRL_TRIM_GO_BIT = 0;
  localparam int CTRL_RANGE_BIT = 1;
  localparam int CTRL_SOFT_PD_BIT = 2;

  // status fields
  localparam int ST_RUNNING_BIT = 0;
  localparam int ST_EXT_BIT = 1;
  localparam int ST_DDR_BIT = 2;
  localparam int ST_EDGE_BIT = 3;
  localparam int ST_RANGE_BIT = 4;
  localparam int ST_WAIT_BIT = 5;
  localparam int ST_PD_BIT = 6;

  // data register fields
  localparam int DATA_OOR_BIT = 16;

  // reset values
  localparam logic [15:0] TRIM_LEN_RST = 16'h0100;

  // counts in sample clock cycles
  localparam logic [7:0] CAL_MIN_LO_CYC = 8'h50;
  localparam logic [7:0] CAL_MIN_HI_CYC = 8'h50;
  localparam logic [15:0] PWRUP_SHORT_CYC = 16'h0100;

  // hclk cycles before the straps are first caught
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // output codes at the range limits
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [7:0] CODE_MIN = 8'h00;

  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_e;
  typedef enum logic [1:0] {T_WAIT, T_IDLE, T_RUN} trim_e;

endpackage

// *** strap_if.sv ***
`timescale 1ns/1ns
interface strap_if;
  logic ext_mode;
  logic ddr_mode;
  logic edge_rise;
  logic range_high;
  logic cal_long;
  modport dec (output ext_mode, ddr_mode, edge_rise, range_high, cal_long);
  modport use_side (input ext_mode, ddr_mode, edge_rise, range_high,
    cal_long);
endinterface

// *** pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync import adc_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // first stage feeds only the second
  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule

// *** strap_decode.sv ***
`timescale 1ns/1ns
module strap_decode import adc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // capture strobe
  input wire logic cap,
  // synchronised pin levels, {above high, below low}
  input wire logic [1:0] edge_lvl,
  input wire logic [1:0] range_lvl,
  input wire logic dly_pin,
  // decoded straps
  strap_if.dec st
);
  typedef struct packed {
    logic ext;
    logic ddr;
    logic edge_r;
    logic range_h;
    logic long_d;
  } strap_s;

  strap_s s_q;
  strap_s s_d;
  level_e edge_l;
  level_e range_l;

  function automatic level_e decode(input logic [1:0] v);
    if (v[1]) begin
      decode = LVL_HIGH;
    end else if (v[0]) begin
      decode = LVL_LOW;
    end else begin
      decode = LVL_MID;
    end
  endfunction

  // latched only on capture so modes cannot drift mid-run
  always_comb begin
    edge_l = decode(edge_lvl);
    range_l = decode(range_lvl);
    s_d = s_q;
    if (cap) begin
      s_d.ext = (range_l == LVL_MID);
      s_d.ddr = (edge_l == LVL_MID) && (range_l != LVL_MID);
      s_d.edge_r = (edge_l == LVL_HIGH);
      s_d.range_h = (range_l == LVL_HIGH);
      s_d.long_d = dly_pin && (range_l != LVL_MID);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st.ext_mode = s_q.ext;
  assign st.ddr_mode = s_q.ddr;
  assign st.edge_rise = s_q.edge_r;
  assign st.range_high = s_q.range_h;
  assign st.cal_long = s_q.long_d;
endmodule

// *** adc_output_demux.sv ***
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// - alternate samples onto two half-rate buses
// - eight-bit offset binary result words
// - delayed bus holds earlier sample, one cycle
// - sample taken on sample clock falling edge
// - edge pin picks strobe edge of changes
// - mid-level edge pin selects double data rate
// - extended mode: edge pin is serial data
// - extended mode: swing pin is serial clock
// - divider reset pulse realigns the output strobe
// - power-down input high clears strobe, buses, flag and trim
// - start pin low then high starts trim
// - mid-level range pin selects extended mode
// - range pin low/high picks input range
// - delay pin selects power-up trim delay
// - extended mode: delay pin is serial select
// - running flag high throughout trim
// - strobe half rate SDR, quarter rate DDR
// - strobe frozen while trim runs
// - over/under range forces 255/0 and flag
module adc_output_demux import adc_pkg::*; #(
  parameter logic [15:0] PWRUP_LONG_CYC = 16'h4000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // converter core
  input wire logic sample_clk,
  input wire logic [7:0] adc_code,
  input wire logic over_pos,
  input wire logic under_neg,
  // strap pins, three-level ones as {above high, below low}
  input wire logic [1:0] strobe_edge_select,
  input wire logic [1:0] range_select,
  input wire logic swing_select,
  input wire logic powerup_trim_delay_select,
  // control pins
  input wire logic strobe_divider_reset,
  input wire logic power_down_input,
  input wire logic trim_start,
  // output buses
  output logic [7:0] delayed_bus,
  output logic [7:0] direct_bus,
  output logic output_strobe,
  output logic out_of_range,
  // status and routed pins
  output logic selftrim_running,
  output logic range_large,
  output logic swing_reduced,
  output logic powered_down,
  output logic serial_in,
  output logic serial_clk,
  output logic serial_select
);
  ////////////////////////////////////////////////////////////////////////
  localparam int SYNC_W = 20;

  typedef struct packed {
    trim_e trim;
    logic [15:0] tcnt;
    logic [7:0] lo_cnt, hi_cnt;
    logic clk_prev, rst_prev, pd_prev;
    logic [1:0] settle;
    logic cap, phase;
    logic [7:0] hold, dly_bus, dir_bus;
    logic oor, strobe, hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] addr;
    logic [15:0] trim_len;
    logic ctrl_range, soft_pd, trim_go, running, pd_out;
    logic range_l, swing_r, ser_in, ser_clk, ser_sel;
  } state_s;

  state_s s_q, s_d;
  logic [SYNC_W-1:0] sync_q;
  logic clk_s;
  logic [7:0] code_s;
  logic over_s, under_s;
  logic [1:0] edge_s, range_s;
  logic swing_s, dly_s, divrst_s, pd_s, start_s;
  logic pd, fall, ev, divrst, accept, go_ok;
  logic [7:0] code;
  logic [15:0] delay_cyc;
  strap_if st ();

  ////////////////////////////////////////////////////////////////////////
  // every pin and the sample clock cross through two flops;
  // code bits assumed settled long before the sample clock falls
  pin_sync #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({sample_clk, adc_code, over_pos, under_neg, strobe_edge_select,
      range_select, swing_select, powerup_trim_delay_select,
      strobe_divider_reset, power_down_input, trim_start}),
    .q(sync_q)
  );

  assign {clk_s, code_s, over_s, under_s, edge_s, range_s, swing_s, dly_s,
    divrst_s, pd_s, start_s} = sync_q;

  strap_decode u_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap(s_q.cap),
    .edge_lvl(edge_s),
    .range_lvl(range_s),
    .dly_pin(dly_s),
    .st(st)
  );

  ////////////////////////////////////////////////////////////////////////
  assign pd = pd_s || s_q.soft_pd;
  assign fall = s_q.clk_prev && !clk_s;
  assign ev = fall && !pd;
  assign divrst = divrst_s && !s_q.rst_prev;
  assign accept = hsel && hready && htrans[1];
  assign code = over_s ? CODE_MAX : (under_s ? CODE_MIN : code_s);
  // extended mode has no long delay choice
  assign delay_cyc = (st.cal_long && !st.ext_mode) ? PWRUP_LONG_CYC
    : PWRUP_SHORT_CYC;

  always_comb begin
    s_d = s_q;
    s_d.cap = 1'b0;
    s_d.trim_go = 1'b0;
    s_d.wr_pend = 1'b0;
    s_d.hready = 1'b1;
    s_d.clk_prev = clk_s;
    s_d.rst_prev = divrst_s;
    s_d.pd_prev = pd;
    // straps caught after reset and again on wake-up
    if (s_q.settle != SETTLE_CYC) begin
      s_d.settle = s_q.settle + 2'h1;
      s_d.cap = (s_q.settle == SETTLE_CYC - 2'h1);
    end
    if (s_q.pd_prev && !pd) begin
      s_d.cap = 1'b1;
    end
    // bus data phase: writes land one cycle after the address
    if (s_q.wr_pend) begin
      case (s_q.addr)
        ADDR_CTRL: begin
          s_d.trim_go = hwdata[CTRL_TRIM_GO_BIT];
          s_d.ctrl_range = hwdata[CTRL_RANGE_BIT];
          s_d.soft_pd = hwdata[CTRL_SOFT_PD_BIT];
        end
        ADDR_TRIM_LEN: begin
          s_d.trim_len = hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    if (accept) begin
      s_d.addr = (haddr[31:4] == 28'h0) ? haddr[7:0] : ADDR_NONE;
      s_d.wr_pend = hwrite;
      s_d.hrdata = 32'h0;
      if (!hwrite && haddr[31:4] == 28'h0) begin
        case (haddr[7:0])
          ADDR_CTRL: begin
            s_d.hrdata[CTRL_RANGE_BIT] = s_q.ctrl_range;
            s_d.hrdata[CTRL_SOFT_PD_BIT] = s_q.soft_pd;
          end
          ADDR_TRIM_LEN: begin
            s_d.hrdata[15:0] = s_q.trim_len;
          end
          ADDR_STATUS: begin
            s_d.hrdata[ST_RUNNING_BIT] = s_q.running;
            s_d.hrdata[ST_EXT_BIT] = st.ext_mode;
            s_d.hrdata[ST_DDR_BIT] = st.ddr_mode;
            s_d.hrdata[ST_EDGE_BIT] = st.edge_rise;
            s_d.hrdata[ST_RANGE_BIT] = s_q.range_l;
            s_d.hrdata[ST_WAIT_BIT] = (s_q.trim == T_WAIT);
            s_d.hrdata[ST_PD_BIT] = s_q.pd_out;
          end
          ADDR_DATA: begin
            s_d.hrdata[15:0] = {s_q.dly_bus, s_q.dir_bus};
            s_d.hrdata[DATA_OOR_BIT] = s_q.oor;
          end
          default: begin
          end
        endcase
      end
    end
    // trim sequencer, timed in sample clock cycles
    case (s_q.trim)
      T_WAIT: begin
        if (ev && s_q.settle == SETTLE_CYC) begin
          if (s_q.tcnt >= delay_cyc) begin
            s_d.trim = T_RUN;
            s_d.tcnt = 16'h0;
          end else begin
            s_d.tcnt = s_q.tcnt + 16'h0001;
          end
        end
      end
      T_IDLE: begin
        if (s_q.trim_go) begin
          s_d.trim = T_RUN;
          s_d.tcnt = 16'h0;
        end else if (ev) begin
          if (!start_s) begin
            s_d.hi_cnt = 8'h0;
            if (s_q.lo_cnt != CAL_MIN_LO_CYC) begin
              s_d.lo_cnt = s_q.lo_cnt + 8'h01;
            end
          end else if (s_q.lo_cnt != CAL_MIN_LO_CYC) begin
            s_d.lo_cnt = 8'h0;
          end else if (s_q.hi_cnt == CAL_MIN_HI_CYC - 8'h01) begin
            s_d.trim = T_RUN;
            s_d.tcnt = 16'h0;
            s_d.lo_cnt = 8'h0;
            s_d.hi_cnt = 8'h0;
          end else begin
            s_d.hi_cnt = s_q.hi_cnt + 8'h01;
          end
        end
      end
      T_RUN: begin
        if (ev) begin
          if (s_q.tcnt >= s_q.trim_len) begin
            s_d.trim = T_IDLE;
          end else begin
            s_d.tcnt = s_q.tcnt + 16'h0001;
          end
        end
      end
      default: begin
        s_d.trim = T_WAIT;
      end
    endcase
    // output demultiplexer; strobe held still during trim
    if (divrst) begin
      s_d.phase = 1'b0;
      s_d.strobe = 1'b0;
    end else if (ev && s_q.trim != T_RUN) begin
      s_d.phase = !s_q.phase;
      if (!s_q.phase) begin
        s_d.hold = code;
        if (!st.ddr_mode) begin
          s_d.strobe = !st.edge_rise;
        end
      end else begin
        s_d.dly_bus = s_q.hold;
        s_d.dir_bus = code;
        s_d.oor = over_s || under_s;
        if (st.ddr_mode) begin
          s_d.strobe = !s_q.strobe;
        end else begin
          s_d.strobe = st.edge_rise;
        end
      end
    end
    // power-down overrides the trim sequencer and demultiplexer and restarts the delay
    if (pd) begin
      s_d.trim = T_WAIT;
      s_d.tcnt = 16'h0;
      s_d.lo_cnt = 8'h0;
      s_d.hi_cnt = 8'h0;
      s_d.phase = 1'b0;
      s_d.strobe = 1'b0;
      s_d.dly_bus = 8'h0;
      s_d.dir_bus = 8'h0;
      s_d.oor = 1'b0;
    end
    s_d.running = (s_d.trim == T_RUN);
    s_d.pd_out = pd;
    s_d.range_l = st.ext_mode ? s_q.ctrl_range : st.range_high;
    s_d.swing_r = !st.ext_mode && !swing_s;
    s_d.ser_in = st.ext_mode && edge_s[1];
    s_d.ser_clk = st.ext_mode && swing_s;
    s_d.ser_sel = st.ext_mode && dly_s;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.trim <= T_WAIT;
      s_q.trim_len <= TRIM_LEN_RST;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hreadyout = s_q.hready;
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign delayed_bus = s_q.dly_bus;
  assign direct_bus = s_q.dir_bus;
  assign output_strobe = s_q.strobe;
  assign out_of_range = s_q.oor;
  assign selftrim_running = s_q.running;
  assign range_large = s_q.range_l;
  assign swing_reduced = s_q.swing_r;
  assign powered_down = s_q.pd_out;
  assign serial_in = s_q.ser_in;
  assign serial_clk = s_q.ser_clk;
  assign serial_select = s_q.ser_sel;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign go_ok = ev && s_q.trim != T_RUN && !divrst;
  AST_PAIR_DELAYED: assert property (
    go_ok && s_q.phase |=> s_q.dly_bus == $past(s_q.hold))
    else $error("delayed bus missed the held sample");
  AST_PAIR_DIRECT: assert property (
    go_ok && s_q.phase |=> s_q.dir_bus == $past(code))
    else $error("direct bus missed the later sample");
  AST_HALF_RATE: assert property (
    go_ok && !s_q.phase |=> $stable(s_q.dly_bus) && $stable(s_q.dir_bus))
    else $error("buses changed on the first sample of a pair");
  AST_FALL_ONLY: assert property (
    !fall && !divrst && !pd |=> $stable(s_q.phase))
    else $error("sample taken without a falling sample clock");
  AST_OOR_FLAG: assert property (
    go_ok && s_q.phase && over_s |=> s_q.oor && s_q.dir_bus == CODE_MAX)
    else $error("over-range not flagged with full code");
  AST_STROBE_FROZEN: assert property (
    s_q.trim == T_RUN && !divrst && !pd |=> $stable(s_q.strobe))
    else $error("strobe moved during trim");
  AST_PD_QUIET: assert property (
    pd |=> !s_q.strobe && s_q.dly_bus == 8'h0 && !s_q.running
      ##1 s_q.pd_out || !pd)
    else $error("outputs active in power-down");
  AST_RUN_FLAG: assert property (
    s_q.running == (s_q.trim == T_RUN))
    else $error("running flag disagrees with trim state");
  AST_DIV_RESET: assert property (
    divrst |=> !s_q.strobe && !s_q.phase)
    else $error("divider reset did not realign strobe");
  AST_SDR_EDGE: assert property (
    go_ok && s_q.phase && !st.ddr_mode |=> s_q.strobe == $past(st.edge_rise))
    else $error("data changed on the wrong strobe edge");
  AST_DDR_RATE: assert property (
    go_ok && !s_q.phase && st.ddr_mode |=> $stable(s_q.strobe))
    else $error("ddr strobe toggled mid pair");
  AST_PIN_START: assert property (
    s_q.trim == T_IDLE && !s_q.trim_go && !pd ##1 s_q.trim == T_RUN
      |-> $past(s_q.lo_cnt) == CAL_MIN_LO_CYC)
    else $error("trim started without a full low phase");
  AST_RANGE: assert property (
    !st.ext_mode && $stable(st.ext_mode)
      |=> s_q.range_l == $past(st.range_high))
    else $error("range output does not follow strap");

  COV_PAIR: cover property (go_ok && s_q.phase);
  COV_TRIM: cover property (s_q.trim == T_IDLE ##1 s_q.trim == T_RUN);
  COV_DIVRST: cover property (divrst);
  COV_DDR: cover property (st.ddr_mode && $changed(s_q.strobe));
endmodule

// *** strobe_capture.sv ***
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// receiving logic: latches the pair at every strobe edge, counts edges
module strobe_capture (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // from the converter
  input wire logic output_strobe,
  input wire logic [7:0] delayed_bus,
  input wire logic [7:0] direct_bus,
  // to the bench
  output int toggles,
  output logic [15:0] word
);
  logic prev_q;
  // one hclk late on purpose: buses change with the strobe, so wait a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      toggles <= 0;
      word <= 16'h0000;
    end else begin
      prev_q <= output_strobe;
      if (output_strobe !== prev_q) begin
        toggles <= toggles + 1;
        word <= {delayed_bus, direct_bus};
      end
    end
  end
endmodule

// *** adc_output_demux_and_pin_control_tb.sv ***
`timescale 1ns/1ns
module adc_output_demux_and_pin_control_tb;
  import adc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0] htrans, edge_pins, range_pins;
  logic [2:0] hsize;
  logic sample_clk, over_pos, under_neg, swing_pin, dly_pin;
  logic [7:0] adc_code, delayed_bus, direct_bus;
  logic div_rst, pd_pin, trim_pin, output_strobe, out_of_range;
  logic running, range_large, swing_reduced, powered_down;
  logic serial_in, serial_clk, serial_select;
  logic [15:0] word;
  int toggles, n, n_errors, compares;
  bit exp_rise, exp_ddr;
  logic [7:0] q[$];
  logic [1:0] etab[3] = '{2'h1, 2'h0, 2'h2};
  logic [1:0] rtab[3] = '{2'h2, 2'h1, 2'h2};
  logic stab[3] = '{1'b0, 1'b1, 1'b1};

  always #5 hclk = ~hclk;

  adc_output_demux #(.PWRUP_LONG_CYC(16'h0020)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_clk(sample_clk), .adc_code(adc_code),
    .over_pos(over_pos), .under_neg(under_neg),
    .strobe_edge_select(edge_pins), .range_select(range_pins),
    .swing_select(swing_pin), .powerup_trim_delay_select(dly_pin),
    .strobe_divider_reset(div_rst), .power_down_input(pd_pin),
    .trim_start(trim_pin), .delayed_bus(delayed_bus),
    .direct_bus(direct_bus), .output_strobe(output_strobe),
    .out_of_range(out_of_range), .selftrim_running(running),
    .range_large(range_large), .swing_reduced(swing_reduced),
    .powered_down(powered_down), .serial_in(serial_in),
    .serial_clk(serial_clk), .serial_select(serial_select)
  );

  strobe_capture u_cap (
    .hclk(hclk), .hresetn(hresetn), .output_strobe(output_strobe),
    .delayed_bus(delayed_bus), .direct_bus(direct_bus),
    .toggles(toggles), .word(word)
  );

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic close_out;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask

  // address phase held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // one sample period of 160 ns; the sample clock idles high between bursts
  task automatic run(input int cnt, input bit cmp, input logic [1:0] lim);
    logic prev;
    prev = output_strobe;
    q.delete();
    for (int i = 0; i < cnt; i++) begin
      seed = xs(seed);
      q.push_back(lim[0] ? CODE_MAX : (lim[1] ? CODE_MIN : seed[7:0]));
      @(posedge hclk);
      adc_code <= seed[7:0];
      over_pos <= lim[0];
      under_neg <= lim[1];
      repeat (7) @(posedge hclk);
      #3 sample_clk = 1'b0;
      repeat (8) @(posedge hclk);
      #3 sample_clk = 1'b1;
      if (cmp && i % 2 == 1) begin
        chk({delayed_bus, direct_bus}, {q[0], q[1]});
        chk(word, {q[0], q[1]});
        chk(out_of_range, |lim);
        chk(output_strobe, exp_ddr ? !prev : exp_rise);
        prev = output_strobe;
        q.delete();
      end else if (cmp && !exp_ddr) begin
        chk(output_strobe, !exp_rise);
      end
    end
  endtask

  task automatic pulse;
    @(posedge hclk);
    div_rst <= 1'b1;
    repeat (3) @(posedge hclk);
    div_rst <= 1'b0;
    settle;
  endtask

  // straps are caught again on power-down exit
  task automatic remode(input logic [1:0] e, input logic [1:0] g,
                        input logic s);
    logic [15:0] held;
    @(posedge hclk);
    pd_pin <= 1'b1;
    settle;
    chk(powered_down, 1'b1);
    held = {delayed_bus, direct_bus};
    run(2, 1'b0, 2'h0);
    chk({delayed_bus, direct_bus}, held);
    edge_pins <= e;
    range_pins <= g;
    swing_pin <= s;
    @(posedge hclk);
    pd_pin <= 1'b0;
    settle;
    chk(powered_down, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
    seed = 32'h00000035; n_errors = 0; compares = 0;
    sample_clk = 1'b1; adc_code = 8'h00; over_pos = 1'b0; under_neg = 1'b0;
    edge_pins = 2'h2; range_pins = 2'h1; swing_pin = 1'b1; dly_pin = 1'b1;
    div_rst = 1'b0; pd_pin = 1'b0; trim_pin = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b0, ADDR_TRIM_LEN, 32'h0, r);
    chk(r[15:0], TRIM_LEN_RST);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_WAIT_BIT], 1'b1);
    chk(r[ST_EXT_BIT], 1'b0);
    chk(r[ST_EDGE_BIT], 1'b1);
    chk(range_large, 1'b0);
    chk(swing_reduced, 1'b0);
    bus(1'b1, ADDR_TRIM_LEN, 32'h00000005, r);
    bus(1'b0, ADDR_TRIM_LEN, 32'h0, r);
    chk(r[15:0], 16'h0005);
    bus(1'b1, 8'h10, 32'hffffffff, r);
    bus(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    // long delay strap: 32 falls of waiting, trim from the 33rd for 6
    run(32, 1'b0, 2'h0);
    chk(running, 1'b0);
    run(1, 1'b0, 2'h0);
    chk(running, 1'b1);
    n = toggles;
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_RUNNING_BIT], 1'b1);
    run(5, 1'b0, 2'h0);
    chk(running, 1'b1);
    chk(toggles, n);
    run(1, 1'b0, 2'h0);
    chk(running, 1'b0);
    pulse;
    exp_rise = 1'b1;
    exp_ddr = 1'b0;
    run(8, 1'b1, 2'h0);
    run(2, 1'b1, 2'h1);
    run(2, 1'b1, 2'h2);
    bus(1'b0, ADDR_DATA, 32'h0, r);
    chk(r, 32'h1 << DATA_OOR_BIT);
    chk(hresp, 1'b0);
    run(1, 1'b0, 2'h0);
    pulse;
    run(4, 1'b1, 2'h0);
    for (int k = 0; k < 3; k++) begin
      remode(etab[k], rtab[k], stab[k]);
      exp_rise = (etab[k] == 2'h2);
      exp_ddr = (etab[k] == 2'h0);
      run(6, 1'b1, 2'h0);
      chk(range_large, rtab[k] == 2'h2);
      chk(swing_reduced, !stab[k]);
      bus(1'b0, ADDR_STATUS, 32'h0, r);
      chk(r[ST_DDR_BIT], exp_ddr);
    end
    // a strap moved while running must not change the mode
    edge_pins <= 2'h0;
    settle;
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_DDR_BIT], 1'b0);
    run(4, 1'b1, 2'h0);
    edge_pins <= 2'h2;
    run(120, 1'b0, 2'h0);
    trim_pin <= 1'b1;
    run(78, 1'b0, 2'h0);
    chk(running, 1'b0);
    run(4, 1'b0, 2'h0);
    chk(running, 1'b1);
    n = toggles;
    run(3, 1'b0, 2'h0);
    chk(toggles, n);
    run(5, 1'b0, 2'h0);
    chk(running, 1'b0);
    trim_pin <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_TRIM_GO_BIT, r);
    settle;
    chk(running, 1'b1);
    n = toggles;
    run(6, 1'b0, 2'h0);
    chk(toggles, n);
    chk(running, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_SOFT_PD_BIT, r);
    settle;
    chk(powered_down, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_PD_BIT], 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0, r);
    settle;
    chk(powered_down, 1'b0);
    dly_pin <= 1'b1;
    remode(2'h2, 2'h0, 1'b0);
    chk(serial_in, 1'b1);
    chk(serial_clk, 1'b0);
    chk(serial_select, 1'b1);
    chk(swing_reduced, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_EXT_BIT], 1'b1);
    swing_pin <= 1'b1;
    edge_pins <= 2'h1;
    settle;
    chk(serial_clk, 1'b1);
    chk(serial_in, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h00000002, r);
    range_pins <= 2'h2;
    settle;
    chk(range_large, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r[ST_EXT_BIT], 1'b1);
    close_out;
  end

  // whole run is near 50 us; five times that means a hang
  initial begin
    #250000;
    n_errors++;
    close_out;
  end
endmodule
